// ===== rtl/dma_ctl_core.sv
// Notes on behaviour
// R1: Writing one triggers request if channel idle
// R2: Trigger bit clears when channel becomes waiting
// R3: Writing one while waiting just holds bit
// R4: Writing zero clears trigger bit
// R5: Per-level enable picks static or round-robin
// R6: Round-robin stores last granted channel number
// R7: Static field x from 1 to 5 ranks x highest
// R8: Field kept when round-robin switched off
// R9: Level fields at 26:24,18:16,10:8,2:0
// R10: Reserved bits read zero
// R11: Channel field shows lowest pending-interrupt channel
// R12: Bit 15 shows selected channel waiting
// R13: Bit 14 shows selected channel busy
// R14: Bit 13 shows selected descriptor fault
// R15: Bit 10 write-one clears halt flag
// R16: Bit 9 write-one clears done flag
// R17: Bit 8 write-one clears fault flag
// R18: Field refreshes, zero if none, writable
// R19: Static field zero ranks ascending
module dma_ctl_core #(
   parameter int NCH = dma_ctl_pkg::NUM_CH
) (
   // Clock, reset, enable
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // Channel state from the transfer engine
   input wire logic [NCH-1:0] ch_waiting_i,
   input wire logic [NCH-1:0] ch_busy_i,
   input wire logic [NCH-1:0] ch_desc_fault_i,
   input wire logic [NCH-1:0] ch_halt_set_i,
   input wire logic [NCH-1:0] ch_done_set_i,
   input wire logic [NCH-1:0] ch_fault_set_i,
   // Per-channel priority level and grant notification
   input wire logic [2*NCH-1:0] ch_level_i,
   input wire logic [NCH-1:0] ch_req_i,
   input wire logic grant_i,
   input wire logic [1:0] grant_level_i,
   input wire logic [2:0] grant_ch_i,
   // Outputs
   output logic [NCH-1:0] soft_req_o,
   output logic [dma_ctl_pkg::NUM_LVL-1:0] lvl_gnt_valid_o,
   output logic [3*dma_ctl_pkg::NUM_LVL-1:0] lvl_gnt_ch_o,
   output logic irq_o
);

   dma_ctl_pkg::reg_req_s req;
   logic [NCH-1:0] trig_q;
   logic [NCH-1:0] soft_req_q;
   logic [dma_ctl_pkg::NUM_LVL-1:0] rr_en_q;
   logic [2:0] lvl_pri_q [dma_ctl_pkg::NUM_LVL];
   dma_ctl_pkg::ch_flags_s flags_q [NCH];
   logic [2:0] sel_q;
   logic [2:0] sel_d;
   logic [dma_ctl_pkg::EV_W-1:0] ev_stat_q;
   logic [dma_ctl_pkg::EV_W-1:0] ev_mask_q;
   logic [31:0] rdata_q;
   logic [NCH-1:0] irq_live;
   logic [NCH-1:0] waiting_prev_q;

   assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

   function automatic logic hit(input dma_ctl_pkg::reg_req_s r, input logic [7:0] ofs);
      hit = (r.addr == ofs);
   endfunction : hit

   function automatic logic [2:0] lowest(input logic [NCH-1:0] v);
      lowest = 3'h0;
      for (int i = NCH - 1; i >= 0; i--) begin
         if (v[i]) begin
            lowest = 3'(i);
         end
      end
   endfunction : lowest

   ////////////////////////////////////////////////////////////////////////
   // Software trigger

   // Trigger bit is held while waiting; it only pulses a request when idle
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         trig_q <= '0;
         soft_req_q <= '0;
         waiting_prev_q <= '0;
      end else if (ce_i) begin
         waiting_prev_q <= ch_waiting_i;
         soft_req_q <= '0;
         for (int c = 0; c < NCH; c++) begin
            if (req.wr && hit(req, dma_ctl_pkg::SWTRIG_OFS)) begin
               if (!req.wdata[c]) begin
                  trig_q[c] <= 1'b0; // see R4
               end else if (ch_waiting_i[c]) begin
                  trig_q[c] <= 1'b1; // see R3
               end else begin
                  trig_q[c] <= 1'b1;
                  soft_req_q[c] <= 1'b1; // see R1
               end
            end else if (ch_waiting_i[c] && !waiting_prev_q[c]) begin
               trig_q[c] <= 1'b0; // see R2
            end
         end
      end
   end

   assign soft_req_o = soft_req_q;

   ////////////////////////////////////////////////////////////////////////
   // Priority control

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         rr_en_q <= '0;
         for (int l = 0; l < dma_ctl_pkg::NUM_LVL; l++) begin
            lvl_pri_q[l] <= 3'h0;
         end
      end else if (ce_i) begin
         if (req.wr && hit(req, dma_ctl_pkg::PRICTRL_OFS)) begin
            for (int l = 0; l < dma_ctl_pkg::NUM_LVL; l++) begin
               // Disabling rotation leaves the field as written or last granted
               rr_en_q[l] <= req.wdata[dma_ctl_pkg::RR_EN_BIT_0 + l * dma_ctl_pkg::LVL_STRIDE]; // see R5 R8
               lvl_pri_q[l] <= req.wdata[l * dma_ctl_pkg::LVL_STRIDE +: 3]; // see R9
            end
         end else if (grant_i && rr_en_q[grant_level_i]) begin
            lvl_pri_q[grant_level_i] <= grant_ch_i; // see R6
         end
      end
   end

   for (genvar g = 0; g < dma_ctl_pkg::NUM_LVL; g++) begin : g_lvl
      logic [NCH-1:0] lvl_req;
      always_comb begin
         for (int c = 0; c < NCH; c++) begin
            lvl_req[c] = ch_req_i[c] && (ch_level_i[2*c +: 2] == 2'(g));
         end
      end
      level_arbiter #(.NCH(NCH)) u_arb (
         .core_clk_i(core_clk_i),
         .sys_rst_i(sys_rst_i),
         .ce_i(ce_i),
         .rr_en_i(rr_en_q[g]),
         .pri_i(lvl_pri_q[g]), // see R7 R19
         .req_i(lvl_req),
         .gnt_valid_o(lvl_gnt_valid_o[g]),
         .gnt_ch_o(lvl_gnt_ch_o[3*g +: 3])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt flags and pending channel

   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         irq_live[c] = flags_q[c].halt | flags_q[c].done | flags_q[c].fault;
      end
   end

   // New events win over a clear in the same cycle
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         for (int c = 0; c < NCH; c++) begin
            flags_q[c] <= '0;
         end
      end else if (ce_i) begin
         for (int c = 0; c < NCH; c++) begin
            logic clr;
            clr = req.wr && hit(req, dma_ctl_pkg::IRQ_CH_OFS) && (sel_q == 3'(c));
            flags_q[c].halt <= ch_halt_set_i[c] |
               (flags_q[c].halt & ~(clr & req.wdata[dma_ctl_pkg::IP_HALT_BIT])); // see R15
            flags_q[c].done <= ch_done_set_i[c] |
               (flags_q[c].done & ~(clr & req.wdata[dma_ctl_pkg::IP_DONE_BIT])); // see R16
            flags_q[c].fault <= ch_fault_set_i[c] |
               (flags_q[c].fault & ~(clr & req.wdata[dma_ctl_pkg::IP_FAULT_BIT])); // see R17
         end
      end
   end

   // Software may point the field anywhere; hardware pulls it to lowest pending
   always_comb begin
      sel_d = sel_q;
      if (req.wr && hit(req, dma_ctl_pkg::IRQ_CH_OFS)) begin
         sel_d = req.wdata[dma_ctl_pkg::IP_ID_LSB +: 3]; // see R18
      end else if (irq_live == '0) begin
         sel_d = 3'h0; // see R18
      end else if (lowest(irq_live) < sel_q || sel_q >= 3'(NCH) || !irq_live[sel_q]) begin
         sel_d = lowest(irq_live); // see R11 R18
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         sel_q <= 3'h0;
      end else if (ce_i) begin
         sel_q <= sel_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Block interrupt

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         ev_stat_q <= '0;
         ev_mask_q <= '0;
      end else if (ce_i) begin
         logic [dma_ctl_pkg::EV_W-1:0] set;
         logic [dma_ctl_pkg::EV_W-1:0] clr;
         set = '0;
         set[dma_ctl_pkg::EV_HALT_BIT] = |ch_halt_set_i;
         set[dma_ctl_pkg::EV_DONE_BIT] = |ch_done_set_i;
         set[dma_ctl_pkg::EV_FAULT_BIT] = |ch_fault_set_i;
         clr = (req.wr && hit(req, dma_ctl_pkg::IRQ_STATUS_OFS)) ?
            req.wdata[dma_ctl_pkg::EV_W-1:0] : '0;
         ev_stat_q <= set | (ev_stat_q & ~clr);
         if (req.wr && hit(req, dma_ctl_pkg::IRQ_MASK_OFS)) begin
            ev_mask_q <= req.wdata[dma_ctl_pkg::EV_W-1:0];
         end
      end
   end

   assign irq_o = |(ev_stat_q & ev_mask_q);

   ////////////////////////////////////////////////////////////////////////
   // Read data

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         rdata_q <= '0;
      end else if (ce_i) begin
         rdata_q <= '0; // see R10
         if (req.rd) begin
            case (req.addr)
               dma_ctl_pkg::SWTRIG_OFS: begin
                  rdata_q[NCH-1:0] <= trig_q;
               end
               dma_ctl_pkg::PRICTRL_OFS: begin
                  for (int l = 0; l < dma_ctl_pkg::NUM_LVL; l++) begin
                     rdata_q[dma_ctl_pkg::RR_EN_BIT_0 + l * dma_ctl_pkg::LVL_STRIDE] <= rr_en_q[l];
                     rdata_q[l * dma_ctl_pkg::LVL_STRIDE +: 3] <= lvl_pri_q[l]; // see R9
                  end
               end
               dma_ctl_pkg::IRQ_CH_OFS: begin
                  rdata_q[dma_ctl_pkg::IP_ID_LSB +: 3] <= sel_q; // see R11
                  if (sel_q < 3'(NCH)) begin
                     rdata_q[dma_ctl_pkg::IP_WAIT_BIT] <= ch_waiting_i[sel_q]; // see R12
                     rdata_q[dma_ctl_pkg::IP_BUSY_BIT] <= ch_busy_i[sel_q]; // see R13
                     rdata_q[dma_ctl_pkg::IP_BAD_DESC_BIT] <= ch_desc_fault_i[sel_q]; // see R14
                     rdata_q[dma_ctl_pkg::IP_HALT_BIT] <= flags_q[sel_q].halt;
                     rdata_q[dma_ctl_pkg::IP_DONE_BIT] <= flags_q[sel_q].done;
                     rdata_q[dma_ctl_pkg::IP_FAULT_BIT] <= flags_q[sel_q].fault;
                  end
               end
               dma_ctl_pkg::IRQ_STATUS_OFS: begin
                  rdata_q[dma_ctl_pkg::EV_W-1:0] <= ev_stat_q;
               end
               dma_ctl_pkg::IRQ_MASK_OFS: begin
                  rdata_q[dma_ctl_pkg::EV_W-1:0] <= ev_mask_q;
               end
               default: begin
                  rdata_q <= '0;
               end
            endcase
         end
      end
   end

   assign reg_rdata_o = rdata_q;

endmodule : dma_ctl_core

// ===== rtl/dma_ctl_pkg.sv
package dma_ctl_pkg;

   // Register map (byte addresses)
   localparam logic [7:0] SWTRIG_OFS = 8'h10;
   localparam logic [7:0] PRICTRL_OFS = 8'h14;
   localparam logic [7:0] IRQ_CH_OFS = 8'h20;
   localparam logic [7:0] IRQ_STATUS_OFS = 8'h40;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h44;

   localparam int NUM_CH = 6;
   localparam int NUM_LVL = 4;

   // Priority control field positions
   localparam int RR_EN_BIT_0 = 7;
   localparam int LVL_STRIDE = 8;
   localparam int LVL_PRI_LSB = 0;
   localparam int LVL_PRI_W = 3;
   localparam logic [31:0] PRICTRL_RST = 32'h0000_0000;

   // Interrupt pending field positions
   localparam int IP_ID_LSB = 0;
   localparam int IP_FAULT_BIT = 8;
   localparam int IP_DONE_BIT = 9;
   localparam int IP_HALT_BIT = 10;
   localparam int IP_BAD_DESC_BIT = 13;
   localparam int IP_BUSY_BIT = 14;
   localparam int IP_WAIT_BIT = 15;

   // Event status/mask layout
   localparam int EV_HALT_BIT = 0;
   localparam int EV_DONE_BIT = 1;
   localparam int EV_FAULT_BIT = 2;
   localparam int EV_W = 3;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;

   typedef struct packed {
      logic halt;
      logic done;
      logic fault;
   } ch_flags_s;

endpackage : dma_ctl_pkg

// ===== rtl/level_arbiter.sv
// Picks one requesting channel of one priority level
module level_arbiter #(
   parameter int NCH = 6
) (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   // Control
   input wire logic rr_en_i,
   input wire logic [2:0] pri_i,
   input wire logic [NCH-1:0] req_i,
   // Result
   output logic gnt_valid_o,
   output logic [2:0] gnt_ch_o
);

   logic [2:0] start;
   logic [2:0] idx;
   logic found;
   logic [2:0] pick;

   // Static: start at pri_i (0 or values of NCH and up give ascending); rr: start after last grant
   always_comb begin
      if (rr_en_i) begin
         start = (pri_i >= 3'(NCH - 1)) ? 3'h0 : 3'(pri_i + 3'h1);
      end else begin
         start = (pri_i >= 3'(NCH)) ? 3'h0 : pri_i;
      end
      found = 1'b0;
      pick = 3'h0;
      idx = start;
      for (int k = 0; k < NCH; k++) begin
         if (!found && req_i[idx]) begin
            found = 1'b1;
            pick = idx;
         end
         idx = (idx == 3'(NCH - 1)) ? 3'h0 : 3'(idx + 3'h1);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         gnt_valid_o <= 1'b0;
         gnt_ch_o <= 3'h0;
      end else if (ce_i) begin
         gnt_valid_o <= found;
         gnt_ch_o <= pick;
      end
   end

endmodule : level_arbiter

// ===== sim/dma_ctl_core_asserts.sv
module dma_ctl_core_asserts #(
   parameter int NCH = 6
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [31:0] reg_rdata_o,
   // Channel side
   input wire logic [NCH-1:0] ch_waiting_i,
   input wire logic [NCH-1:0] ch_halt_set_i,
   input wire logic [NCH-1:0] ch_done_set_i,
   input wire logic [NCH-1:0] ch_fault_set_i,
   input wire logic [2*NCH-1:0] ch_level_i,
   input wire logic [NCH-1:0] ch_req_i,
   // Outputs
   input wire logic [NCH-1:0] soft_req_o,
   input wire logic [3:0] lvl_gnt_valid_o,
   input wire logic [11:0] lvl_gnt_ch_o,
   input wire logic irq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [NCH-1:0] l0_req;
   logic sw_wr;
   assign sw_wr = ce_i && reg_wr_i && (reg_addr_i == dma_ctl_pkg::SWTRIG_OFS);
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         l0_req[c] = ch_req_i[c] && (ch_level_i[2*c+:2] == 2'h0);
      end
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i || !ce_i);
   ////////////////////////////////////////////////////////////////////////////////
   property p_trig_req;
      sw_wr |=> soft_req_o == ($past(reg_wdata_i[NCH-1:0]) & ~$past(ch_waiting_i));
   endproperty
   property p_trig_hold;
      sw_wr && |(reg_wdata_i[NCH-1:0] & ch_waiting_i) |=> !(|(soft_req_o & $past(ch_waiting_i)));
   endproperty
   property p_req_cause;
      |soft_req_o |-> $past(sw_wr);
   endproperty
   property p_sw_rsvd;
      reg_rd_i && reg_addr_i == dma_ctl_pkg::SWTRIG_OFS |=> reg_rdata_o[31:6] == 26'h0;
   endproperty
   property p_pri_rsvd;
      reg_rd_i && reg_addr_i == dma_ctl_pkg::PRICTRL_OFS |=> (reg_rdata_o & 32'h7878_7878) == 32'h0;
   endproperty
   property p_ip_rsvd;
      reg_rd_i && reg_addr_i == dma_ctl_pkg::IRQ_CH_OFS |=> (reg_rdata_o & 32'hFFFF_18F8) == 32'h0;
   endproperty
   property p_gnt_valid;
      1'b1 |=> lvl_gnt_valid_o[0] == $past(|l0_req);
   endproperty
   property p_gnt_one;
      $onehot(l0_req) |=> (NCH'(1) << lvl_gnt_ch_o[2:0]) == $past(l0_req);
   endproperty
   property p_irq_rise;
      $rose(irq_o) |-> $past(reg_wr_i || |{ch_halt_set_i, ch_done_set_i, ch_fault_set_i});
   endproperty
   a_trig_req: assert property (p_trig_req)
      else $error("soft request mismatch");
   a_trig_hold: assert property (p_trig_hold)
      else $error("request while waiting");
   a_req_cause: assert property (p_req_cause)
      else $error("request without write");
   a_sw_rsvd: assert property (p_sw_rsvd)
      else $error("trigger reserved bits set");
   a_pri_rsvd: assert property (p_pri_rsvd)
      else $error("priority reserved bits set");
   a_ip_rsvd: assert property (p_ip_rsvd)
      else $error("pending reserved bits set");
   a_gnt_valid: assert property (p_gnt_valid)
      else $error("level grant valid wrong");
   a_gnt_one: assert property (p_gnt_one)
      else $error("single requester not granted");
   a_irq_rise: assert property (p_irq_rise)
      else $error("interrupt without cause");
   c_trig: cover property (|soft_req_o);
   c_irq: cover property ($rose(irq_o));
   c_gnt: cover property ($onehot(l0_req) ##1 lvl_gnt_valid_o[0]);
endmodule : dma_ctl_core_asserts

// ===== sim/tb_dma_ctl_core.sv
module tb_dma_ctl_core;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic ce_i = 1'b1;
   logic [7:0] reg_addr_i = 8'h00;
   logic [31:0] reg_wdata_i = 32'h0;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [5:0] ch_waiting_i = 6'h0, ch_busy_i = 6'h0, ch_desc_fault_i = 6'h0;
   logic [5:0] ch_halt_set_i = 6'h0, ch_done_set_i = 6'h0, ch_fault_set_i = 6'h0;
   logic [5:0] ch_req_i = 6'h0;
   logic [11:0] ch_level_i = 12'h0;
   logic grant_i = 1'b0;
   logic [1:0] grant_level_i = 2'h0;
   logic [2:0] grant_ch_i = 3'h0;
   logic [31:0] reg_rdata_o;
   logic [5:0] soft_req_o;
   logic [3:0] lvl_gnt_valid_o;
   logic [11:0] lvl_gnt_ch_o;
   logic irq_o;
   int miscompares = 0;
   int num_checks = 0;
   int cycles = 0;
   always #5 core_clk_i = ~core_clk_i;
   dma_ctl_core #(.NCH(6)) uut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .ch_waiting_i(ch_waiting_i),
      .ch_busy_i(ch_busy_i), .ch_desc_fault_i(ch_desc_fault_i), .ch_halt_set_i(ch_halt_set_i),
      .ch_done_set_i(ch_done_set_i), .ch_fault_set_i(ch_fault_set_i), .ch_level_i(ch_level_i),
      .ch_req_i(ch_req_i), .grant_i(grant_i), .grant_level_i(grant_level_i),
      .grant_ch_i(grant_ch_i), .soft_req_o(soft_req_o), .lvl_gnt_valid_o(lvl_gnt_valid_o),
      .lvl_gnt_ch_o(lvl_gnt_ch_o), .irq_o(irq_o));
   ////////////////////////////////////////////////////////////////////////////////
   task chk(string n, logic [31:0] e, logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task stop_test;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : stop_test
   // Generous ceiling: the whole sequence needs about 110 cycles
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         stop_test();
      end
   end
   task wr(logic [7:0] a, logic [31:0] d);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
   endtask : wr
   task rd(logic [7:0] a, logic [31:0] e);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      @(negedge core_clk_i);
      chk($sformatf("rdata %h", a), e, reg_rdata_o);
      @(posedge core_clk_i);
   endtask : rd
   // Write, then look at the one-cycle request pulse and the interrupt level
   task wrq(logic [7:0] a, logic [31:0] d, logic [31:0] e, logic irq_e);
      wr(a, d);
      @(negedge core_clk_i);
      chk("soft_req", e, 32'(soft_req_o));
      chk("irq", 32'(irq_e), 32'(irq_o));
      @(posedge core_clk_i);
   endtask : wrq
   ////////////////////////////////////////////////////////////////////////////////
   task t_trig;
      for (int c = 0; c < 6; c++) begin
         wrq(dma_ctl_pkg::SWTRIG_OFS, 32'h1 << c, 32'h1 << c, 1'b0);
         rd(dma_ctl_pkg::SWTRIG_OFS, 32'h1 << c);
      end
      ch_waiting_i <= 6'h20;
      repeat (2) @(posedge core_clk_i);
      rd(dma_ctl_pkg::SWTRIG_OFS, 32'h0);
      wrq(dma_ctl_pkg::SWTRIG_OFS, 32'hFFFF_FFE0, 32'h0, 1'b0);
      rd(dma_ctl_pkg::SWTRIG_OFS, 32'h20);
      wr(dma_ctl_pkg::SWTRIG_OFS, 32'h0);
      rd(dma_ctl_pkg::SWTRIG_OFS, 32'h0);
      ch_waiting_i <= 6'h0;
   endtask : t_trig
   task arb(int lv, logic [2:0] f, logic [5:0] rq, logic [2:0] e);
      ch_level_i <= {6{2'(lv)}};
      wr(dma_ctl_pkg::PRICTRL_OFS, 32'(f) << (8 * lv));
      ch_req_i <= rq;
      @(posedge core_clk_i);
      @(negedge core_clk_i);
      chk("grant", {28'h0, 1'b1, e}, 32'({lvl_gnt_valid_o[lv], lvl_gnt_ch_o[3*lv+:3]}));
      @(posedge core_clk_i);
   endtask : arb
   task t_pri;
      arb(0, 3'h0, 6'h3F, 3'h0);
      arb(0, 3'h0, 6'h04, 3'h2);
      arb(1, 3'h3, 6'h03, 3'h0);
      arb(2, 3'h3, 6'h23, 3'h5);
      arb(3, 3'h2, 6'h13, 3'h4);
      wr(dma_ctl_pkg::PRICTRL_OFS, 32'h0000_0080);
      grant_ch_i <= 3'h4;
      grant_i <= 1'b1;
      @(posedge core_clk_i);
      grant_i <= 1'b0;
      rd(dma_ctl_pkg::PRICTRL_OFS, 32'h0000_0084);
      ch_level_i <= 12'h0;
      ch_req_i <= 6'h30;
      @(posedge core_clk_i);
      @(negedge core_clk_i);
      chk("grant", 32'hD, 32'({lvl_gnt_valid_o[0], lvl_gnt_ch_o[2:0]}));
      @(posedge core_clk_i);
      arb(0, 3'h4, 6'h30, 3'h4);
      rd(dma_ctl_pkg::PRICTRL_OFS, 32'h0000_0004);
      wr(dma_ctl_pkg::PRICTRL_OFS, 32'hFDFD_FDFD);
      rd(dma_ctl_pkg::PRICTRL_OFS, 32'h8585_8585);
      ch_req_i <= 6'h0;
   endtask : t_pri
   task t_irq;
      wr(dma_ctl_pkg::IRQ_MASK_OFS, 32'h7);
      {ch_waiting_i, ch_busy_i, ch_desc_fault_i} <= {3{6'h02}};
      {ch_halt_set_i, ch_done_set_i, ch_fault_set_i} <= {6'h02, 6'h08, 6'h20};
      @(posedge core_clk_i);
      {ch_halt_set_i, ch_done_set_i, ch_fault_set_i} <= 18'h0;
      rd(dma_ctl_pkg::IRQ_STATUS_OFS, 32'h7);
      wrq(dma_ctl_pkg::IRQ_MASK_OFS, 32'h0, 32'h0, 1'b0);
      wrq(dma_ctl_pkg::IRQ_MASK_OFS, 32'h7, 32'h0, 1'b1);
      wrq(dma_ctl_pkg::IRQ_STATUS_OFS, 32'h7, 32'h0, 1'b0);
      rd(dma_ctl_pkg::IRQ_CH_OFS, 32'hE401);
      // The written field holds for one cycle before it moves to the next pending channel
      wr(dma_ctl_pkg::IRQ_CH_OFS, 32'h0400);
      @(posedge core_clk_i);
      rd(dma_ctl_pkg::IRQ_CH_OFS, 32'h0203);
      wr(dma_ctl_pkg::IRQ_CH_OFS, 32'h0003);
      rd(dma_ctl_pkg::IRQ_CH_OFS, 32'h0203);
      wr(dma_ctl_pkg::IRQ_CH_OFS, 32'h0200);
      @(posedge core_clk_i);
      rd(dma_ctl_pkg::IRQ_CH_OFS, 32'h0105);
      wr(dma_ctl_pkg::IRQ_CH_OFS, 32'h0105);
      @(posedge core_clk_i);
      rd(dma_ctl_pkg::IRQ_CH_OFS, 32'h0000);
   endtask : t_irq
   // Clock enable low: a trigger write must leave no trace
   task t_ce;
      ce_i <= 1'b0;
      wrq(dma_ctl_pkg::SWTRIG_OFS, 32'h1, 32'h0, 1'b0);
      ce_i <= 1'b1;
      rd(dma_ctl_pkg::SWTRIG_OFS, 32'h0);
   endtask : t_ce
   initial begin
      repeat (10) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      rd(dma_ctl_pkg::PRICTRL_OFS, 32'h0);
      rd(dma_ctl_pkg::IRQ_CH_OFS, 32'h0);
      rd(8'h3C, 32'h0);
      t_trig();
      t_pri();
      t_irq();
      t_ce();
      stop_test();
   end
endmodule : tb_dma_ctl_core
bind dma_ctl_core dma_ctl_core_asserts #(.NCH(NCH)) u_asserts (.core_clk_i(core_clk_i),
   .sys_rst_i(sys_rst_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .ch_waiting_i(ch_waiting_i), .ch_halt_set_i(ch_halt_set_i), .ch_done_set_i(ch_done_set_i),
   .ch_fault_set_i(ch_fault_set_i), .ch_level_i(ch_level_i), .ch_req_i(ch_req_i),
   .soft_req_o(soft_req_o), .lvl_gnt_valid_o(lvl_gnt_valid_o), .lvl_gnt_ch_o(lvl_gnt_ch_o),
   .irq_o(irq_o));
